/* include/ccs_pkg.sv */
// system clock source select: shared offsets, field layout, reset values and state codes
// assumes a 32-bit classic wishbone slave with word-aligned registers
package ccs_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_SYS_CTRL  = 8'h00;
   localparam logic [7:0] OFF_LOOP_CTRL = 8'h04;
   localparam logic [7:0] OFF_STATUS    = 8'h08;

   // system_control_reg0 layout
   localparam int SEL_LSB = 0;

   // loop_control_reg0 layout
   localparam int DIV1_LSB   = 0;
   localparam int DIV1_W     = 10;
   localparam int IN_DIV_FIELD_LSB   = 10;
   localparam int IN_DIV_FIELD_W     = 4;
   localparam int MULT_FIELD_LSB   = 14;
   localparam int MULT_FIELD_W     = 7;
   localparam int K2_LSB     = 21;
   localparam int K2_W       = 7;
   localparam int REFINT_BIT = 30;
   localparam int BYPASS_BIT = 31;

   // status register layout
   localparam int ACT_LSB  = 0;
   localparam int SW_LSB   = 2;
   localparam int LOCK_BIT = 4;

   // clock_source_select codes; 01 is unused and runs from the wakeup clock
   localparam logic [1:0] SEL_WAKE = 2'h0;
   localparam logic [1:0] SEL_LOOP = 2'h2;
   localparam logic [1:0] SEL_EXT  = 2'h3;

   // reset values
   localparam logic [1:0]        SEL_RST    = 2'h0;
   localparam logic              BYPASS_RST = 1'h1;
   localparam logic              REFINT_RST = 1'h1;
   localparam logic [DIV1_W-1:0] DIV1_RST   = 10'h000;
   localparam logic [IN_DIV_FIELD_W-1:0] IN_DIV_FIELD_RST   = 4'h0;
   localparam logic [MULT_FIELD_W-1:0] MULT_FIELD_RST   = 7'h00;
   localparam logic [K2_W-1:0]   K2_RST     = 7'h00;

   // digital vco model: phase accumulator width and start increment
   localparam int          NCO_W       = 16;
   localparam logic [15:0] NCO_INC_RST = 16'h0800;
   localparam logic [15:0] NCO_INC_MAX = 16'h7fff;

   // on-chip source: half period in clk_sys cycles
   localparam logic [15:0] INT_HALF_CYC = 16'h0004;

   // active source, gray along wake -> prescaler -> loop -> direct
   typedef enum logic [1:0] {
      SRC_WAKE = 2'h0,
      SRC_PRE  = 2'h1,
      SRC_PLL  = 2'h3,
      SRC_EXT  = 2'h2
   } ccs_src_e;

   // source switch sequence
   typedef enum logic [1:0] {
      SW_RUN   = 2'h0,
      SW_DRAIN = 2'h1,
      SW_WAIT  = 2'h3
   } ccs_sw_e;

endpackage

/* logic/ccs_pin_sync.sv */
// three-stage synchroniser for slow clock pins
// assumes pin levels are far slower than clk_sys; a level counts once stages two and three agree
`timescale 1ns/1ps
module ccs_pin_sync #(
   parameter int W = 3
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } ccs_sync_s;

   ccs_sync_s st_reg;
   ccs_sync_s st_next;

   // stage one feeds stage two only; a bit follows once s2 and s3 agree
   always_comb begin
      st_next     = st_reg;
      st_next.s1  = pinIn;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      st_next.lvl = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.lvl & (st_reg.s2 ^ st_reg.s3));
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.lvl;

endmodule

/* logic/ccs_clock_select.sv */
// system clock source select: wishbone registers, prescaler, digital loop model, glitch-free mux
// assumes source clocks on pins are well below half of clk_sys; all are resampled on clk_sys
`timescale 1ns/1ps
module ccs_clock_select (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        extClkPin,
   input  wire logic        oscPin,
   input  wire logic        wakeClkPin,
   output logic             sysClkOut
);

   typedef struct packed {
      logic [1:0]               sel;
      logic                     bypass;
      logic                     refInt;
      logic [ccs_pkg::DIV1_W-1:0] div1;
      logic [ccs_pkg::IN_DIV_FIELD_W-1:0] in_div_field;
      logic [ccs_pkg::MULT_FIELD_W-1:0] mult_field;
      logic [ccs_pkg::K2_W-1:0]   out_div2_field;
      logic                     ack;
      logic [31:0]              rdat;
      logic [15:0]              intCnt;
      logic                     intClk;
      logic                     refPrev;
      logic [ccs_pkg::DIV1_W-1:0] preCnt;
      logic                     preClk;
      logic [ccs_pkg::NCO_W-1:0]  acc;
      logic [ccs_pkg::NCO_W-1:0]  inc;
      logic                     vcoPrev;
      logic [ccs_pkg::IN_DIV_FIELD_W-1:0] winCnt;
      logic [7:0]               vcoCnt;
      logic                     locked;
      logic [ccs_pkg::K2_W-1:0]   k2Cnt;
      logic                     k2Clk;
      ccs_pkg::ccs_src_e        active;
      ccs_pkg::ccs_sw_e         sw;
      ccs_pkg::ccs_src_e        pend;
      logic                     pendPrev;
      logic                     sysClk;
   } ccs_state_s;

   ccs_state_s st_reg;
   ccs_state_s st_next;
   logic [2:0] pinLvl;
   logic       extLvl;
   logic       oscLvl;
   logic       wakeLvl;

   // pins come from foreign clocks, so they pass the three-stage synchroniser
   ccs_pin_sync #(
      .W (3)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pinIn   ({wakeClkPin, oscPin, extClkPin}),
      .level   (pinLvl)
   );

   assign extLvl  = pinLvl[0];
   assign oscLvl  = pinLvl[1];
   assign wakeLvl = pinLvl[2];

   // loop_control_reg0 as software sees it
   function automatic logic [31:0] loopImage(input ccs_state_s s);
      logic [31:0] v;
      v = '0;
      v[ccs_pkg::DIV1_LSB +: ccs_pkg::DIV1_W] = s.div1;
      v[ccs_pkg::IN_DIV_FIELD_LSB +: ccs_pkg::IN_DIV_FIELD_W] = s.in_div_field;
      v[ccs_pkg::MULT_FIELD_LSB +: ccs_pkg::MULT_FIELD_W] = s.mult_field;
      v[ccs_pkg::K2_LSB +: ccs_pkg::K2_W]     = s.out_div2_field;
      v[ccs_pkg::REFINT_BIT]                 = s.refInt;
      v[ccs_pkg::BYPASS_BIT]                 = s.bypass;
      return v;
   endfunction

   // byte-lane merge of a write into an old register image
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
                                              input logic [3:0] be);
      logic [31:0] v;
      v = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            v[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return v;
   endfunction

   logic                     busHit;
   logic [7:0]               adrWord;
   logic [31:0]              loopNew;
   logic                     refLvl;
   logic                     refRise;
   logic                     vcoLvl;
   logic                     vcoRise;
   logic [ccs_pkg::DIV1_W:0] k1;
   logic [ccs_pkg::K2_W:0]   k2;
   logic [7:0]               nTarget;
   logic                     pllEn;
   ccs_pkg::ccs_src_e        tgt;
   logic [3:0]               srcLvl;

   always_comb begin
      st_next = st_reg;
      busHit  = wb_cyc_i && wb_stb_i && !st_reg.ack;
      adrWord = {wb_adr_i[7:2], 2'h0};
      loopNew = mergeBytes(loopImage(st_reg), wb_dat_i, wb_sel_i);

      // classic wishbone: one ack per request, dropped the cycle after; unmapped reads give zero
      st_next.ack  = busHit;
      st_next.rdat = '0;
      if (busHit && !wb_we_i) begin
         unique case (adrWord)
            ccs_pkg::OFF_SYS_CTRL: st_next.rdat = {30'h0, st_reg.sel};
            ccs_pkg::OFF_LOOP_CTRL: st_next.rdat = loopImage(st_reg);
            ccs_pkg::OFF_STATUS: st_next.rdat = {27'h0, st_reg.locked, st_reg.sw, st_reg.active};
            default: st_next.rdat = '0;
         endcase
      end
      // fields change together per write; software orders writes sensibly
      if (busHit && wb_we_i) begin
         if (adrWord == ccs_pkg::OFF_SYS_CTRL && wb_sel_i[0]) begin
            st_next.sel = wb_dat_i[ccs_pkg::SEL_LSB +: 2];
         end
         if (adrWord == ccs_pkg::OFF_LOOP_CTRL) begin
            st_next.div1   = loopNew[ccs_pkg::DIV1_LSB +: ccs_pkg::DIV1_W];
            st_next.in_div_field   = loopNew[ccs_pkg::IN_DIV_FIELD_LSB +: ccs_pkg::IN_DIV_FIELD_W];
            st_next.mult_field   = loopNew[ccs_pkg::MULT_FIELD_LSB +: ccs_pkg::MULT_FIELD_W];
            st_next.out_div2_field  = loopNew[ccs_pkg::K2_LSB +: ccs_pkg::K2_W];
            st_next.refInt = loopNew[ccs_pkg::REFINT_BIT];
            st_next.bypass = loopNew[ccs_pkg::BYPASS_BIT];
         end
      end

      // on-chip clock source, a free square wave
      if (st_reg.intCnt >= ccs_pkg::INT_HALF_CYC - 16'h0001) begin
         st_next.intCnt = '0;
         st_next.intClk = !st_reg.intClk;
      end else begin
         st_next.intCnt = st_reg.intCnt + 16'h0001;
      end

      // reference is either the oscillator pin or the on-chip source
      refLvl          = st_reg.refInt ? st_reg.intClk : oscLvl;
      refRise         = refLvl && !st_reg.refPrev;
      st_next.refPrev = refLvl;

      // prescaler: k1 = field + 1, up to 1024; divide by one passes the reference level itself
      k1 = {1'b0, st_reg.div1} + 11'h001;
      if (refRise) begin
         st_next.preCnt = (st_reg.preCnt >= st_reg.div1) ? '0 : st_reg.preCnt + 10'h001;
      end else if (st_reg.preCnt > st_reg.div1) begin
         st_next.preCnt = '0;
      end
      st_next.preClk = (st_reg.div1 == '0) ? refLvl : (st_next.preCnt < k1[ccs_pkg::DIV1_W:1]);

      // digital vco: phase accumulator whose increment is trimmed one step per window
      // the loop keeps running while it still drives the output, else a switch away freezes mid-pulse
      pllEn   = ((st_reg.sel == ccs_pkg::SEL_LOOP) && !st_reg.bypass) || (st_reg.active == ccs_pkg::SRC_PLL);
      vcoLvl  = st_reg.acc[ccs_pkg::NCO_W-1];
      vcoRise = vcoLvl && !st_reg.vcoPrev;
      nTarget = {1'b0, st_reg.mult_field} + 8'h01;
      st_next.vcoPrev = vcoLvl;
      if (!pllEn) begin
         st_next.acc    = '0;
         st_next.winCnt = '0;
         st_next.vcoCnt = '0;
         st_next.locked = 1'b0;
      end else begin
         st_next.acc = st_reg.acc + st_reg.inc;
         if (vcoRise && st_reg.vcoCnt != 8'hff) begin
            st_next.vcoCnt = st_reg.vcoCnt + 8'h01;
         end
         // a window spans p reference periods and should hold n vco periods
         if (refRise) begin
            if (st_reg.winCnt >= st_reg.in_div_field) begin
               st_next.winCnt = '0;
               st_next.vcoCnt = {7'h0, vcoRise};
               st_next.locked = (st_reg.vcoCnt == nTarget);
               // one lsb per window keeps the frequency ramp smooth
               if (st_reg.vcoCnt < nTarget && st_reg.inc != ccs_pkg::NCO_INC_MAX) begin
                  st_next.inc = st_reg.inc + 16'h0001;
               end else if (st_reg.vcoCnt > nTarget && st_reg.inc != 16'h0001) begin
                  st_next.inc = st_reg.inc - 16'h0001;
               end
            end else begin
               st_next.winCnt = st_reg.winCnt + 4'h1;
            end
         end
      end

      // output divisor k2 on the vco
      k2 = {1'b0, st_reg.out_div2_field} + 8'h01;
      if (vcoRise) begin
         st_next.k2Cnt = (st_reg.k2Cnt >= st_reg.out_div2_field) ? '0 : st_reg.k2Cnt + 7'h01;
      end else if (st_reg.k2Cnt > st_reg.out_div2_field) begin
         st_next.k2Cnt = '0;
      end
      st_next.k2Clk = (st_reg.out_div2_field == '0) ? vcoLvl : (st_next.k2Cnt < k2[ccs_pkg::K2_W:1]);

      // wanted source from the select field
      unique case (st_reg.sel)
         ccs_pkg::SEL_EXT: tgt = ccs_pkg::SRC_EXT;
         ccs_pkg::SEL_LOOP: tgt = st_reg.bypass ? ccs_pkg::SRC_PRE : ccs_pkg::SRC_PLL;
         default: tgt = ccs_pkg::SRC_WAKE;
      endcase
      srcLvl = '0;
      srcLvl[ccs_pkg::SRC_WAKE] = wakeLvl;
      srcLvl[ccs_pkg::SRC_PRE]  = st_reg.preClk;
      srcLvl[ccs_pkg::SRC_PLL]  = st_reg.k2Clk;
      srcLvl[ccs_pkg::SRC_EXT]  = extLvl;

      // glitch-free switch: finish the old high phase, hold low, join the new source on its falling edge
      // joining on a mere low level could cut the new low phase short; a source that never falls stalls the switch
      st_next.pendPrev = srcLvl[st_reg.pend];
      unique case (st_reg.sw)
         ccs_pkg::SW_RUN: begin
            st_next.sysClk = srcLvl[st_reg.active];
            if (tgt != st_reg.active) begin
               st_next.sw   = ccs_pkg::SW_DRAIN;
               st_next.pend = tgt;
            end
         end
         ccs_pkg::SW_DRAIN: begin
            st_next.sysClk = srcLvl[st_reg.active] && st_reg.sysClk;
            if (!st_next.sysClk) begin
               st_next.sw = ccs_pkg::SW_WAIT;
            end
         end
         ccs_pkg::SW_WAIT: begin
            st_next.sysClk = 1'b0;
            if (st_reg.pendPrev && !srcLvl[st_reg.pend]) begin
               st_next.active = st_reg.pend;
               st_next.sw     = ccs_pkg::SW_RUN;
            end
         end
         default: begin
            st_next.sysClk = 1'b0;
            st_next.sw     = ccs_pkg::SW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg        <= '0;
         st_reg.sel    <= ccs_pkg::SEL_RST;
         st_reg.bypass <= ccs_pkg::BYPASS_RST;
         st_reg.refInt <= ccs_pkg::REFINT_RST;
         st_reg.div1   <= ccs_pkg::DIV1_RST;
         st_reg.in_div_field   <= ccs_pkg::IN_DIV_FIELD_RST;
         st_reg.mult_field   <= ccs_pkg::MULT_FIELD_RST;
         st_reg.out_div2_field  <= ccs_pkg::K2_RST;
         st_reg.inc    <= ccs_pkg::NCO_INC_RST;
         st_reg.active <= ccs_pkg::SRC_WAKE;
         st_reg.sw     <= ccs_pkg::SW_RUN;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o  = st_reg.rdat;
   assign wb_ack_o  = st_reg.ack;
   assign sysClkOut = st_reg.sysClk;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   chk_direct_follow: assert property (
      (st_reg.sw == ccs_pkg::SW_RUN && st_reg.active == ccs_pkg::SRC_EXT && tgt == ccs_pkg::SRC_EXT)
      |=> sysClkOut == $past(extLvl)) else $error("direct drive not followed");
   chk_wake_follow: assert property (
      (st_reg.sw == ccs_pkg::SW_RUN && st_reg.active == ccs_pkg::SRC_WAKE && tgt == ccs_pkg::SRC_WAKE)
      |=> sysClkOut == $past(wakeLvl)) else $error("wakeup clock not followed");
   chk_pre_pass: assert property (
      (st_reg.div1 == '0) |=> st_reg.preClk == $past(refLvl)) else $error("divide by one not passing");
   chk_pre_range: assert property ($stable(st_reg.div1) |-> st_reg.preCnt <= st_reg.div1) else $error("prescaler overrun");
   chk_k2_range: assert property ($stable(st_reg.out_div2_field) |-> st_reg.k2Cnt <= st_reg.out_div2_field) else $error("k2 overrun");
   chk_loop_smooth: assert property (
      st_reg.inc == $past(st_reg.inc) || st_reg.inc == $past(st_reg.inc) + 16'h0001
      || st_reg.inc == $past(st_reg.inc) - 16'h0001) else $error("loop frequency jumped");
   chk_switch_low: assert property (
      (st_reg.sw == ccs_pkg::SW_WAIT) |-> !sysClkOut) else $error("clock high while switching");
   chk_loop_off: assert property (!pllEn |=> !st_reg.locked) else $error("lock shown while loop off");

   cov_switch_ext: cover property (st_reg.sw == ccs_pkg::SW_WAIT ##1 st_reg.active == ccs_pkg::SRC_EXT);
   cov_loop_lock: cover property (!st_reg.locked ##1 st_reg.locked);
   cov_prescale: cover property (st_reg.active == ccs_pkg::SRC_PRE && st_reg.div1 != '0 && sysClkOut);

endmodule

/* verification/ccs_src_model.sv */
// free-running clock sources seen by the clock select block: direct clock pin, oscillator pin, wakeup clock
// assumes half periods are given in ns and are several clk_sys cycles long; phases are unrelated to clk_sys
`timescale 1ns/1ps
module ccs_src_model (
   input  wire logic [15:0] extHiNs,
   input  wire logic [15:0] extLoNs,
   input  wire logic [15:0] oscHalfNs,
   input  wire logic [15:0] wakeHalfNs,
   output logic             extClkPin,
   output logic             oscPin,
   output logic             wakeClkPin
);
   // direct clock with an uneven duty, so a pass-through must keep high and low times apart
   initial begin
      extClkPin = 1'b0;
      #3.3;
      forever begin
         extClkPin = 1'b1;
         #(extHiNs);
         extClkPin = 1'b0;
         #(extLoNs);
      end
   end

   // oscillator and wakeup clocks; a new half period takes effect at the next half, never mid-phase
   initial begin
      oscPin = 1'b0;
      #7.1;
      forever begin
         #(oscHalfNs) oscPin = ~oscPin;
      end
   end
   initial begin
      wakeClkPin = 1'b0;
      #1.7;
      forever begin
         #(wakeHalfNs) wakeClkPin = ~wakeClkPin;
      end
   end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the clock select block: wishbone register access and period of the generated clock
// assumes the source model in ccs_src_model and the shared constants of ccs_pkg
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys;
   logic        rst;
   logic        wbCyc;
   logic        wbStb;
   logic        wbWe;
   logic [7:0]  wbAdr;
   logic [31:0] wbDatI;
   logic [31:0] wbDatO;
   logic        wbAck;
   logic        extClkPin;
   logic        oscPin;
   logic        wakeClkPin;
   logic        sysClkOut;
   logic        prevClk;
   logic        armed;
   logic [15:0] oscHalfNs;
   logic [31:0] rd;
   logic [31:0] v;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          shortPulses = 0;
   int          runLen = 0;
   int          cycles = 0;
   int          lastHi;
   int          h;
   int          d;

   ccs_clock_select i_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .extClkPin(extClkPin), .oscPin(oscPin), .wakeClkPin(wakeClkPin), .sysClkOut(sysClkOut));
   ccs_src_model i_src (.extHiNs(16'h0032), .extLoNs(16'h0046), .oscHalfNs(oscHalfNs), .wakeHalfNs(16'h0064),
      .extClkPin(extClkPin), .oscPin(oscPin), .wakeClkPin(wakeClkPin));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // hang guard, well above the longest expected run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_mismatch++;
         results();
      end
   end

   // run lengths of the generated clock; the sources never stay in a level under 3 cycles
   always @(posedge clk_sys) begin
      prevClk <= sysClkOut;
      if (rst) begin
         armed <= 1'b0;
         runLen <= 0;
      end else if (sysClkOut !== prevClk) begin
         if (armed && runLen < 3) shortPulses <= shortPulses + 1;
         armed <= 1'b1;
         runLen <= 1;
      end else runLen <= runLen + 1;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // measured counts carry a cycle of resampling jitter, hence a tolerance
   task automatic chkNear(input string what, input int exp, input int got, input int tol);
      num_checks++;
      if (got < exp - tol || got > exp + tol) begin
         n_mismatch++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // one classic wishbone cycle; held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
      int t;
      t = 0;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= wd;
      do begin
         @(posedge clk_sys);
         t++;
      end while (wbAck !== 1'b1 && t < 16);
      rdat = wbDatO;
      if (wbAck !== 1'b1) chk("ack", 32'h1, {31'h0, wbAck});
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   function automatic logic [31:0] lw(input logic byp, input logic refi, input int d1, input int pd, input int nd,
                                      input int k2);
      return {byp, refi, 2'h0, 7'(k2), 7'(nd), 4'(pd), 10'(d1)};
   endfunction

   // park on the wakeup clock until the switch settles, then dividers, then select, so no mix is ever live
   task automatic cfg(input logic [1:0] sel, input logic [31:0] loopWord);
      wb(1'b1, ccs_pkg::OFF_SYS_CTRL, {30'h0, ccs_pkg::SEL_WAKE}, rd);
      rd = 32'hf;
      for (int t = 0; t < 3000 && rd[3:0] != 4'h0; t++) begin
         wb(1'b0, ccs_pkg::OFF_STATUS, 32'h0, rd);
      end
      chk("parked", 32'h0, {28'h0, rd[3:0]});
      wb(1'b1, ccs_pkg::OFF_LOOP_CTRL, loopWord, rd);
      wb(1'b1, ccs_pkg::OFF_SYS_CTRL, {30'h0, sel}, rd);
   endtask

   task automatic measure(input int n, input int lim, output int tot, output int hi);
      int c;
      int r;
      logic p;
      c = 0;
      r = 0;
      tot = 0;
      hi = 0;
      p = sysClkOut;
      while (r <= n && c < lim) begin
         @(posedge clk_sys);
         c++;
         if (sysClkOut === 1'b1 && p === 1'b0) r++;
         if (r >= 1 && r <= n) tot++;
         if (r == 1 && sysClkOut === 1'b1) hi++;
         p = sysClkOut;
      end
   endtask

   // first two periods after a switch are discarded, then n periods are timed
   task automatic meas(input string what, input int n, input int expTot, input int tol);
      int tot;
      int lim;
      lim = (expTot / n) * (n + 2) + 64;
      measure(1, lim, tot, lastHi);
      measure(n, lim, tot, lastHi);
      chkNear(what, expTot, tot, tol);
   endtask

   task automatic stat(input string what, input logic [1:0] src);
      wb(1'b0, ccs_pkg::OFF_STATUS, 32'h0, rd);
      chk(what, {30'h0, src}, {30'h0, rd[1:0]});
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbDatI = 32'h0;
      oscHalfNs = 16'h0028;
      void'($urandom(41));
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      // reset values, read-write, read-only and unmapped places
      wb(1'b0, ccs_pkg::OFF_SYS_CTRL, 32'h0, rd);
      chk("select reset", {30'h0, ccs_pkg::SEL_RST}, rd);
      wb(1'b0, ccs_pkg::OFF_LOOP_CTRL, 32'h0, rd);
      chk("loop reset", lw(ccs_pkg::BYPASS_RST, ccs_pkg::REFINT_RST, 0, 0, 0, 0), rd);
      stat("status reset", ccs_pkg::SRC_WAKE);
      v = $urandom & 32'hcfffffff;
      wb(1'b1, ccs_pkg::OFF_LOOP_CTRL, v, rd);
      wb(1'b0, ccs_pkg::OFF_LOOP_CTRL, 32'h0, rd);
      chk("loop readback", v, rd & 32'hcfffffff);
      wb(1'b1, 8'h0c, $urandom, rd);
      wb(1'b0, 8'h0c, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      wb(1'b1, ccs_pkg::OFF_STATUS, 32'hffffffff, rd);
      stat("status read only", ccs_pkg::SRC_WAKE);
      $display("test registers done");
      // direct drive keeps the uneven duty of the pin
      cfg(ccs_pkg::SEL_EXT, lw(1'b1, 1'b1, 0, 0, 0, 0));
      meas("direct period", 4, 48, 2);
      chkNear("direct high", 5, lastHi, 1);
      stat("direct active", ccs_pkg::SRC_EXT);
      $display("test direct done");
      // prescaler from the oscillator pin, random rates and small factors so each step stays limited
      for (int i = 0; i < 4; i++) begin
         h = 4 + $urandom % 4;
         d = (i == 0) ? 0 : $urandom % 4;
         oscHalfNs <= 16'(h * 10);
         cfg(ccs_pkg::SEL_LOOP, lw(1'b1, 1'b0, d, 0, 0, 0));
         meas("prescale period", 4, 8 * h * (d + 1), 2);
         if (d == 0) chkNear("divide one high", h, lastHi, 1);
      end
      stat("prescale active", ccs_pkg::SRC_PRE);
      oscHalfNs <= 16'h0028;
      cfg(ccs_pkg::SEL_LOOP, lw(1'b1, 1'b0, 1023, 0, 0, 0));
      meas("largest divide", 1, 8192, 2);
      cfg(ccs_pkg::SEL_LOOP, lw(1'b1, 1'b1, 0, 0, 0, 0));
      meas("internal reference", 4, 8 * int'(ccs_pkg::INT_HALF_CYC), 1);
      $display("test prescaler done");
      // wakeup clock, also from the unused select code
      for (int s = 0; s < 2; s++) begin
         cfg(2'(s), lw(1'b1, 1'b1, 0, 0, 0, 0));
         meas("wakeup period", 4, 80, 2);
         stat("wakeup active", ccs_pkg::SRC_WAKE);
      end
      $display("test wakeup done");
      // loop modes whose vco settles at a period of 32 cycles: {ref half, in_div_field, mult_field, out_div2_field}
      for (int i = 0; i < 3; i++) begin
         h = (i == 1) ? 64 : 32;
         d = (i == 2) ? 1 : 0;
         oscHalfNs <= 16'(h * 10);
         cfg(ccs_pkg::SEL_LOOP, lw(1'b0, 1'b0, 0, d, (i == 0) ? 1 : 3, (i == 1) ? 3 : 1));
         rd = 32'h0;
         // poll until locked and the switch onto the loop has finished
         for (int t = 0; t < 400 && rd[ccs_pkg::LOCK_BIT:0] !== {1'b1, ccs_pkg::SW_RUN, ccs_pkg::SRC_PLL}; t++) begin
            wb(1'b0, ccs_pkg::OFF_STATUS, 32'h0, rd);
         end
         chk("loop lock", 32'h1, {31'h0, rd[ccs_pkg::LOCK_BIT]});
         stat("loop active", ccs_pkg::SRC_PLL);
         meas("loop period", 4, 4 * (2 * h * (d + 1) * ((i == 1) ? 4 : 2)) / ((i == 0) ? 2 : 4), 4);
      end
      $display("test loop done");
      chk("short pulses", 32'h0, shortPulses);
      results();
   end
endmodule
